// *** core/sltsr_ctl.sv ***
`timescale 1ns/100ps
module sltsr_ctl (
	input wire logic ref_clk, // Phase clock.
	input wire logic rst_n, // Synchronous reset, active low.
	sltsr_if.ctl lnk, // Link to the device.
	input wire logic wr_req, // Write a bit into the loops.
	input wire logic wr_bit, // Bit to write.
	input wire logic erase_req, // Erase the bit at output.
	input wire logic [1:0] len_sel, // Long loop length select.
	input wire logic [6:0] ff_terms, // Flip-flop set and reset terms.
	input wire logic [2:0] word_in, // Word to load in parallel.
	input wire logic word_valid, // Word offered.
	output logic word_ready, // Room in the buffer.
	input wire logic shift_right, // Shift right request.
	input wire logic shift_left, // Shift left request.
	input wire logic serial_bit, // Serial bit for a shift.
	output logic [2:0] sr_word, // Register contents.
	output logic loop_bit, // Stored bit seen at output.
	output logic [11:0] t_pulse // Digit timing pulses.
);
	logic [2:0] f_data;
	logic f_valid;
	logic f_take;
	logic pend_wr;
	logic pend_bit;
	// Parallel words queue in a buffer and drain one per digit.
	sltsr_fifo #(.WIDTH(3), .DEPTH(sltsr_pkg::FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_data(word_in),
		.in_valid(word_valid),
		.in_ready(word_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_take)
	);
	// Sync pulses only on the phase before output bound the rate.
	assign f_take = f_valid && lnk.clock_phase_index == 2'h2;
	// A write request is held until the phase before the output.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pend_wr <= 1'b0;
			pend_bit <= 1'b0;
		end else if (wr_req) begin
			pend_wr <= 1'b1;
			pend_bit <= wr_bit;
		end else if (lnk.clock_phase_index == 2'h2)
			pend_wr <= 1'b0;
	end
	// Drive the device's lines from flip-flops.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lnk.loop_write <= 1'b0;
			lnk.loop_inhibit <= 1'b0;
			lnk.loop_erase <= 1'b0;
			lnk.loop_shorten <= 1'b0;
			lnk.loop_lengthen <= 1'b0;
			lnk.ff_terms <= 7'h02;
			lnk.par_in <= '0;
			lnk.par_sync <= 1'b0;
			lnk.sr_right_in <= 1'b0;
			lnk.sr_right_sync <= 1'b0;
			lnk.sr_left_in <= 1'b0;
			lnk.sr_left_sync <= 1'b0;
		end else begin
			lnk.loop_write <= pend_wr && pend_bit
				&& lnk.clock_phase_index == 2'h1;
			lnk.loop_inhibit <= pend_wr
				&& lnk.clock_phase_index == 2'h1;
			lnk.loop_erase <= erase_req && lnk.clock_phase_index == 2'h3;
			lnk.loop_shorten <= len_sel == 2'h1;
			lnk.loop_lengthen <= len_sel == 2'h2;
			lnk.ff_terms <= ff_terms;
			lnk.par_in <= f_data;
			lnk.par_sync <= f_take;
			lnk.sr_right_in <= serial_bit;
			lnk.sr_right_sync <= shift_right && !f_take;
			lnk.sr_left_in <= serial_bit;
			lnk.sr_left_sync <= shift_left && !shift_right && !f_take;
		end
	end
	// User-side copies of device outputs.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sr_word <= '0;
			loop_bit <= 1'b0;
			t_pulse <= '0;
		end else begin
			sr_word <= lnk.sr_word;
			loop_bit <= lnk.loop_out;
			t_pulse <= lnk.t_pulse;
		end
	end
endmodule

// *** core/sltsr_dev.sv ***
`timescale 1ns/100ps
// How it works
// - Every amplifier stage delays by one phase.
// - N-digit loop holds N bits, recirculating.
// - Inhibit one phase early removes a bit.
// - Stored stream read on output phase.
// - Writer gives new bit with inhibit early.
// - One-bit loop set early, pulses every digit.
// - Inhibit early clears the flip-flop.
// - Example set and reset terms.
// - Erase one phase after output removes bit.
// - Long loop 11, 12 or 13 digits.
// - Twelve unique digit pulses per word.
// - Three-digit countdown starts with first output.
// - Four-digit countdown likewise, period four.
// - Pulse j is A(j mod 3) and B(j mod 4).
// - Three stages with right and left gating.
// - Serial or parallel load and read.
// - Serial access at either end.
// - Up to one shift per digit; the model takes one shift per cycle.
// - Movement only with a sync pulse.
// - Parallel load comes with its sync.
// - Each serial input comes with its sync.
module sltsr_dev #(
	parameter int LOOP_DIGITS = 4 // Digits of the short storage loop.
) (
	input wire logic ref_clk, // Phase clock.
	input wire logic rst_n, // Synchronous reset, active low.
	sltsr_if.dev lnk // Link to the control logic.
);
	localparam int LP = LOOP_DIGITS * sltsr_pkg::PHASES;
	localparam int LN = sltsr_pkg::LONG_LONG * sltsr_pkg::PHASES;
	localparam int PH = sltsr_pkg::PHASES;
	initial begin
		if (LOOP_DIGITS < 1)
			$error("loop must hold at least one digit");
		// The phase counter is two bits, so a digit must be four phases.
		if (sltsr_pkg::PHASES != 4)
			$error("phase counter serves four phases only");
		// The blender assumes the two count-downs span one whole word.
		if (sltsr_pkg::WORD_DIGITS !=
				sltsr_pkg::CNT3_LEN * sltsr_pkg::CNT4_LEN)
			$error("word length must be the product of the count-downs");
	end
	logic [1:0] phase;
	logic [LP-1:0] loop_line;
	logic [LN-1:0] long_line;
	logic [PH-1:0] ff_line;
	logic [2:0] cnt3;
	logic [3:0] cnt4;
	logic [2:0] sr;
	logic at_out;
	logic at_pre;
	logic at_post;
	logic loop_tap;
	logic long_tap;
	logic ff_tap;
	logic ff_set;
	logic ff_clr;
	// Values entering the short loop and flip-flop lines; the amplifier output shows them too.
	logic loop_in;
	logic ff_in;
	logic [11:0] next_t;

	// Index j of a twelve-digit word maps to count-down outputs.
	function automatic logic blend(input int j, input logic [2:0] a,
			input logic [3:0] b);
		int n;
		int m;
		n = (j % 3 == 0) ? 2 : (j % 3) - 1;
		m = (j % 4 == 0) ? 3 : (j % 4) - 1;
		return a[n] && b[m];
	endfunction

	// Phase counter; one cycle is one phase, four make a digit.
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			phase <= '0;
		else
			phase <= phase + 2'h1;
	end
	assign at_out = phase == sltsr_pkg::OUT_PHASE;
	assign at_pre = phase == sltsr_pkg::OUT_PHASE - 2'h1;
	assign at_post = phase == 2'h0;

	// A bit entered on the phase before output has moved through every
	// stage of its line when that phase comes round again, so the tap is
	// the last stage. Taking an earlier stage would lose the bit, since
	// the entry gate is shut on all the other phases.
	assign loop_tap = loop_line[LP-1];
	assign ff_tap = ff_line[PH-1];
	always_comb begin
		unique case (sltsr_pkg::sltsr_len_t'({lnk.loop_lengthen,
				lnk.loop_shorten}))
			sltsr_pkg::sltsr_len_short:
				long_tap = long_line[sltsr_pkg::LONG_SHORT*PH-1];
			sltsr_pkg::sltsr_len_long:
				long_tap = long_line[sltsr_pkg::LONG_LONG*PH-1];
			default:
				long_tap = long_line[sltsr_pkg::LONG_NOM*PH-1];
		endcase
	end

	// Short loop: a bit kept unless inhibited, a write joins it.
	// Inhibit and write together overwrite the slot with the new bit.
	assign loop_in = at_pre &&
		((loop_tap && !lnk.loop_inhibit) || lnk.loop_write);
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			loop_line <= '0;
		else
			loop_line <= {loop_line[LP-2:0], loop_in};
	end

	// The write bit doubles as the long loop entry gate; an erase sits
	// one phase late, so it acts on the bit just leaving the output.
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			long_line <= '0;
		else begin
			long_line <= {long_line[LN-2:0], at_pre &&
				(long_tap || lnk.loop_write)};
			// On the phase after output that bit is moving into stage
			// two, so the clear overrides the shift there.
			if (at_post && lnk.loop_erase)
				long_line[2] <= 1'b0;
		end
	end

	// Example flip-flop terms: t,s,r,b,a,e,d in bits 6..0.
	assign ff_set = (lnk.ff_terms[6] && lnk.ff_terms[5] && lnk.ff_terms[4])
		|| (lnk.ff_terms[3] && !lnk.ff_terms[2]);
	assign ff_clr = !lnk.ff_terms[1] || lnk.ff_terms[0];
	// Set wins over reset so a coinciding set is not lost.
	assign ff_in = at_pre && (ff_set || (ff_tap && !ff_clr));
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			ff_line <= '0;
		else
			ff_line <= {ff_line[PH-2:0], ff_in};
	end

	// Count-down loops step once per digit at the output phase.
	// Each holds a single circulating one, so it can never go empty.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt3 <= sltsr_pkg::CNT3_RESET;
			cnt4 <= sltsr_pkg::CNT4_RESET;
		end else if (at_out) begin
			cnt3 <= {cnt3[1:0], cnt3[2]};
			cnt4 <= {cnt4[2:0], cnt4[3]};
		end
	end
	always_comb begin
		for (int j = 1; j <= sltsr_pkg::WORD_DIGITS; j++)
			next_t[j-1] = blend(j, cnt3, cnt4);
	end

	// Shift register, stage one on the left; parallel load wins.
	// A move needs no phase alignment, so any rate up to one per cycle
	// is served; the control side passes one shift request per cycle.
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			sr <= sltsr_pkg::SR_RESET;
		else if (lnk.par_sync)
			sr <= lnk.par_in;
		else if (lnk.sr_right_sync)
			sr <= {sr[1:0], lnk.sr_right_in};
		else if (lnk.sr_left_sync)
			sr <= {lnk.sr_left_in, sr[2:1]};
	end

	// Registered outputs; loop outputs pulse on the output phase only.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lnk.loop_out <= 1'b0;
			lnk.ff_out <= 1'b0;
			lnk.t_pulse <= '0;
			lnk.clock_phase_index <= '0;
			lnk.sr_right_out <= 1'b0;
			lnk.sr_left_out <= 1'b0;
		end else begin
			lnk.loop_out <= loop_in;
			lnk.ff_out <= ff_in;
			lnk.t_pulse <= at_pre ? next_t : '0;
			lnk.clock_phase_index <= phase + 2'h1;
			lnk.sr_right_out <= sr[2];
			lnk.sr_left_out <= sr[0];
		end
	end
	// The word is the register itself, so it shows a move one cycle
	// after its sync without a second copy lagging behind.
	assign lnk.sr_word = sr;
	// The long loop content is internal only; its tap is unused outside.
	// It is kept so the length select and erase paths stay exercised.
	logic unused_long;
	assign unused_long = long_tap;
endmodule

// *** core/sltsr_fifo.sv ***
`timescale 1ns/100ps
module sltsr_fifo #(
	parameter int WIDTH = 3, // Word width.
	parameter int DEPTH = 8 // Words held.
) (
	input wire logic ref_clk, // Clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [WIDTH-1:0] in_data, // Word in.
	input wire logic in_valid, // Word in is offered.
	output logic in_ready, // Room for a word.
	output logic [WIDTH-1:0] out_data, // Word out.
	output logic out_valid, // Word out is present.
	input wire logic out_ready // Drain takes the word.
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic do_wr;
	logic do_rd;
	// Pointers carry one extra bit so full and empty stay distinct.
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	// Storage writes.
	always_ff @(posedge ref_clk) begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	// Pointer moves.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// *** core/sltsr_if.sv ***
`timescale 1ns/100ps
interface sltsr_if;
	// Storage loop write side.
	logic loop_write;
	logic loop_inhibit;
	logic loop_erase;
	logic loop_shorten;
	logic loop_lengthen;
	logic loop_out;
	// Dynamic flip-flop set and reset terms.
	logic [6:0] ff_terms;
	logic ff_out;
	// Timing pulses and phase.
	logic [11:0] t_pulse;
	logic [1:0] clock_phase_index;
	// Shift register.
	logic [2:0] par_in;
	logic par_sync;
	logic sr_right_in;
	logic sr_right_sync;
	logic sr_left_in;
	logic sr_left_sync;
	logic [2:0] sr_word;
	logic sr_right_out;
	logic sr_left_out;
	modport dev (
		input loop_write, loop_inhibit, loop_erase, loop_shorten,
		input loop_lengthen, ff_terms, par_in, par_sync,
		input sr_right_in, sr_right_sync, sr_left_in, sr_left_sync,
		output loop_out, ff_out, t_pulse, clock_phase_index,
		output sr_word, sr_right_out, sr_left_out
	);
	modport ctl (
		output loop_write, loop_inhibit, loop_erase, loop_shorten,
		output loop_lengthen, ff_terms, par_in, par_sync,
		output sr_right_in, sr_right_sync, sr_left_in, sr_left_sync,
		input loop_out, ff_out, t_pulse, clock_phase_index,
		input sr_word, sr_right_out, sr_left_out
	);
endinterface

// *** core/sltsr_pkg.sv ***
package sltsr_pkg;
	// Phases per digit period; one clock cycle stands for one phase.
	localparam int PHASES = 4;
	localparam int CLK_PERIOD_NS = 8;
	localparam int DIGIT_NS = 1000;
	// Digit periods of the long loop: nominal, short and long.
	localparam int LONG_NOM = 12;
	localparam int LONG_SHORT = 11;
	localparam int LONG_LONG = 13;
	localparam int WORD_DIGITS = 12;
	localparam int CNT3_LEN = 3;
	localparam int CNT4_LEN = 4;
	localparam int SR_STAGES = 3;
	localparam int FIFO_DEPTH = 8;
	// Reset values of the stores and of the count-down loops.
	localparam logic [2:0] SR_RESET = 3'h0;
	localparam logic [2:0] CNT3_RESET = 3'h1;
	localparam logic [3:0] CNT4_RESET = 4'h1;
	// Phase within the digit on which loop outputs are valid.
	localparam logic [1:0] OUT_PHASE = 2'h3;
	// Long loop length select codes.
	typedef enum logic [1:0] {
		sltsr_len_nom = 2'h0,
		sltsr_len_short = 2'h1,
		sltsr_len_long = 2'h2
	} sltsr_len_t;
endpackage

// *** sim/sltsr_asserts.sv ***
`timescale 1ns/100ps
module sltsr_asserts (
	input wire logic ref_clk, // Phase clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic loop_out, // Loop output.
	input wire logic [6:0] ff_terms, // Flip-flop terms.
	input wire logic ff_out, // Flip-flop output.
	input wire logic [11:0] t_pulse, // Digit pulses.
	input wire logic [1:0] clock_phase_index, // Phase now.
	input wire logic [2:0] par_in, // Parallel word.
	input wire logic par_sync, // Parallel load sync.
	input wire logic sr_right_in, // Right serial input.
	input wire logic sr_right_sync, // Right shift sync.
	input wire logic sr_left_in, // Left serial input.
	input wire logic sr_left_sync, // Left shift sync.
	input wire logic [2:0] sr_word // Register contents.
);
	// All checks share the phase clock and its reset.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Terms are judged on the phase just before the output phase.
	logic ff_set, ff_clr, any_sync;
	assign ff_set = &ff_terms[6:4] | (ff_terms[3] & !ff_terms[2]);
	assign ff_clr = !ff_terms[1] | ff_terms[0];
	assign any_sync = par_sync | sr_right_sync | sr_left_sync;
	property p_phase;
		$past(rst_n) |-> clock_phase_index == $past(clock_phase_index) + 2'h1;
	endproperty
	a_phase: assert property (p_phase)
		else $error("phase did not advance by one");
	property p_out_phase;
		(loop_out | ff_out | (|t_pulse)) |->
			clock_phase_index == sltsr_pkg::OUT_PHASE;
	endproperty
	a_out_phase: assert property (p_out_phase)
		else $error("pulse outside the output phase");
	property p_tp_onehot;
		clock_phase_index == sltsr_pkg::OUT_PHASE |-> $onehot(t_pulse);
	endproperty
	a_tp_onehot: assert property (p_tp_onehot)
		else $error("digit pulses not one-hot");
	property p_tp_next;
		(t_pulse != 12'h000) |-> ##4 t_pulse == {$past(t_pulse[10:0], 4),
			$past(t_pulse[11], 4)};
	endproperty
	a_tp_next: assert property (p_tp_next)
		else $error("digit pulse order broken");
	property p_ff_set;
		clock_phase_index == 2'h2 && ff_set |=> ff_out;
	endproperty
	a_ff_set: assert property (p_ff_set)
		else $error("flip-flop not set");
	property p_ff_keep;
		ff_out ##3 !ff_clr |=> ff_out;
	endproperty
	a_ff_keep: assert property (p_ff_keep)
		else $error("flip-flop lost its state");
	property p_ff_clr;
		clock_phase_index == 2'h2 && ff_clr && !ff_set |=> !ff_out;
	endproperty
	a_ff_clr: assert property (p_ff_clr)
		else $error("flip-flop not cleared");
	property p_hold;
		!any_sync |=> $stable(sr_word);
	endproperty
	a_hold: assert property (p_hold)
		else $error("register moved without sync");
	property p_par;
		par_sync |=> sr_word == $past(par_in);
	endproperty
	a_par: assert property (p_par)
		else $error("parallel load wrong");
	property p_right;
		sr_right_sync && !par_sync |=>
			sr_word == {$past(sr_word[1:0]), $past(sr_right_in)};
	endproperty
	a_right: assert property (p_right)
		else $error("right shift wrong");
	property p_left;
		sr_left_sync && !par_sync && !sr_right_sync |=>
			sr_word == {$past(sr_left_in), $past(sr_word[2:1])};
	endproperty
	a_left: assert property (p_left)
		else $error("left shift wrong");
endmodule

// *** sim/tb_serial_loop_timing_shift.sv ***
`timescale 1ns/100ps
module tb_serial_loop_timing_shift;
	logic ref_clk = 1'h0, rst_n = 1'h0, wr_req = 1'h0, wr_bit = 1'h0;
	logic erase_req = 1'h0, word_valid = 1'h0, shift_right = 1'h0;
	logic shift_left = 1'h0, serial_bit = 1'h0, word_ready, loop_bit;
	logic [1:0] len_sel = 2'h0;
	logic [6:0] ff_terms = 7'h02;
	logic [2:0] word_in = 3'h0, sr_word;
	logic [11:0] t_pulse;
	logic [6:0] terms [4] = '{7'h72, 7'h03, 7'h0a, 7'h00};
	int n_errors = 0, samples_checked = 0, f, l, k;
	sltsr_if sltsr_if_inst ();
	sltsr_dev #(.LOOP_DIGITS(4)) sltsr_dev_inst (.ref_clk(ref_clk),
		.rst_n(rst_n), .lnk(sltsr_if_inst));
	sltsr_ctl sltsr_ctl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.lnk(sltsr_if_inst), .wr_req(wr_req), .wr_bit(wr_bit),
		.erase_req(erase_req), .len_sel(len_sel), .ff_terms(ff_terms),
		.word_in(word_in), .word_valid(word_valid), .word_ready(word_ready),
		.shift_right(shift_right), .shift_left(shift_left),
		.serial_bit(serial_bit), .sr_word(sr_word), .loop_bit(loop_bit),
		.t_pulse(t_pulse));
	sltsr_asserts sltsr_asserts_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.loop_out(sltsr_if_inst.loop_out), .ff_terms(sltsr_if_inst.ff_terms),
		.ff_out(sltsr_if_inst.ff_out), .t_pulse(sltsr_if_inst.t_pulse),
		.clock_phase_index(sltsr_if_inst.clock_phase_index),
		.par_in(sltsr_if_inst.par_in), .par_sync(sltsr_if_inst.par_sync),
		.sr_right_in(sltsr_if_inst.sr_right_in),
		.sr_right_sync(sltsr_if_inst.sr_right_sync),
		.sr_left_in(sltsr_if_inst.sr_left_in),
		.sr_left_sync(sltsr_if_inst.sr_left_sync),
		.sr_word(sltsr_if_inst.sr_word));
	// One phase is one cycle of 8 ns.
	always #4 ref_clk = ~ref_clk;
	task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic check_cnt(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: count %0d want %0d", $time, got, exp);
		end
	endtask
	// Pulses are counted on the link itself, settled after each edge.
	task automatic count_pulses(input int n);
		f = 0;
		l = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			f += int'(sltsr_if_inst.ff_out === 1'h1);
			l += int'(sltsr_if_inst.loop_out === 1'h1);
		end
		@(negedge ref_clk);
	endtask
	// The control side adds buffer and register delay, so wait bounded.
	task automatic wait_word(input logic [2:0] w);
		for (k = 0; k < 40 && sr_word !== w; k++) @(negedge ref_clk);
		check_val(12'(sr_word), 12'(w));
	endtask
	// A word is held until the buffer shows room at a sampling edge.
	task automatic load(input logic [2:0] w);
		word_in = w;
		word_valid = 1'h1;
		do @(posedge ref_clk); while (word_ready !== 1'h1);
		@(negedge ref_clk);
		word_valid = 1'h0;
		wait_word(w);
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// A hang is cut after 6000 cycles, more than fifteen times the expected run length.
	initial begin
		#(8 * 6000);
		n_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		complete_run();
	end
	// Inputs move on the falling edge only.
	initial begin
		repeat (2) @(negedge ref_clk);
		check_val(12'(sr_word), 12'h000);
		rst_n = 1'h1;
		for (k = 0; k < 20 && t_pulse === 12'h000; k++) @(negedge ref_clk);
		check_val(t_pulse, 12'h001);
		for (int j = 1; j < 24; j++) begin
			repeat (4) @(negedge ref_clk);
			check_val(t_pulse, 12'h001 << (j % 12));
		end
		load(3'h5);
		load(3'h2);
		shift_right = 1'h1;
		serial_bit = 1'h1;
		@(negedge ref_clk);
		shift_right = 1'h0;
		wait_word(3'h5);
		shift_left = 1'h1;
		serial_bit = 1'h0;
		@(negedge ref_clk);
		shift_left = 1'h0;
		wait_word(3'h2);
		repeat (20) @(negedge ref_clk);
		check_val(12'(sr_word), 12'h002);
		// Three shifts in a row, one per cycle, fill with ones.
		shift_right = 1'h1;
		serial_bit = 1'h1;
		repeat (3) @(negedge ref_clk);
		shift_right = 1'h0;
		wait_word(3'h7);
		// Set, clear, set by the other term, clear by the low enable.
		for (int i = 0; i < 4; i++) begin
			ff_terms = terms[i];
			repeat (8) @(negedge ref_clk);
			ff_terms = 7'h02;
			count_pulses(16);
			check_cnt(f, (i % 2 == 0) ? 4 : 0);
		end
		// One bit written into a four-digit loop comes round every 16.
		len_sel = 2'h1;
		wr_req = 1'h1;
		wr_bit = 1'h1;
		@(negedge ref_clk);
		wr_req = 1'h0;
		count_pulses(32);
		check_cnt(l, 2);
		len_sel = 2'h2;
		erase_req = 1'h1;
		wr_req = 1'h1;
		wr_bit = 1'h0;
		repeat (16) @(negedge ref_clk);
		wr_req = 1'h0;
		erase_req = 1'h0;
		count_pulses(32);
		check_cnt(l, 0);
		complete_run();
	end
endmodule
